// [core/difr_defines.svh]
// Purpose: constants for the digital input function router
// Assumes: 32-bit AXI4-Lite register window, 12-bit byte address
// Notes: register offsets are byte addresses
`ifndef DIFR_DEFINES_SVH
`define DIFR_DEFINES_SVH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define DIFR_ADDR_W 12
`define DIFR_TERMS 10
`define DIFR_SEL_TERMS 4
`define DIFR_CODES 76
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define DIFR_OFF_SEL1 12'h000
`define DIFR_OFF_SEL2 12'h004
`define DIFR_OFF_SEL3 12'h008
`define DIFR_OFF_SEL4 12'h00c
`define DIFR_OFF_STATUS 12'h010
`define DIFR_OFF_COUNT 12'h014
// ----------------------------------------------------------------
// reset values of the selects
// ----------------------------------------------------------------
`define DIFR_RST_SEL1 16'h0001
`define DIFR_RST_SEL2 16'h002a
`define DIFR_RST_SEL3 16'h0000
`define DIFR_RST_SEL4 16'h0000
// ----------------------------------------------------------------
// function codes used by the block
// ----------------------------------------------------------------
`define DIFR_FN_NONE 0
`define DIFR_FN_TQ_FWD 5
`define DIFR_FN_TQ_NEG 6
`define DIFR_FN_ENC_CLR 15
`define DIFR_FN_SPD0 17
`define DIFR_FN_SPD3 20
`define DIFR_FN_GEAR1 24
`define DIFR_FN_SEG0 28
`define DIFR_FN_SEG3 31
`define DIFR_FN_RSV_A 33
`define DIFR_FN_MODE0 36
`define DIFR_FN_MODE1 37
`define DIFR_FN_FL_EN 38
`define DIFR_FN_FL_REL 39
`define DIFR_FN_FL_TRG 40
`define DIFR_FN_LIM_POS 43
`define DIFR_FN_LIM_REV 44
`define DIFR_FN_GEAR2 56
`define DIFR_FN_EVT_CNT 61
`define DIFR_FN_EVT_CLR 62
`define DIFR_FN_RAMP_UP 63
`define DIFR_FN_RAMP_DN 64
`define DIFR_FN_RAMP_HOLD 65
`define DIFR_FN_RSV_B 71
// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define DIFR_RESP_OKAY 2'b00
`define DIFR_RESP_SLVERR 2'b10
`endif

// [core/difr_pkg.sv]
// Purpose: shared types of the digital input function router
// Assumes: constants come from difr_defines.svh
// Notes: types only
package difr_pkg;
  // one function-select register
  typedef logic [15:0] difr_sel_type;
  // one bus answer code
  typedef logic [1:0] difr_resp_type;
endpackage

// [core/difr_router.sv]
// Purpose: routes digital input terminals onto drive functions
// Assumes: terminal pins asynchronous, high means active
// Notes: selects and status reached over AXI4-Lite
//
// Overview of operation
// - code 15 clears encoder position count
// - code 61 pulses increment event counter
// - code 62 clears event counter
// - codes 17-20 give speed index bits 0-3
// - codes 28-31 give segment index bits 0-3
// - codes 36, 37 give control-mode bits
// - codes 63-65 give ramp up, down, hold
// - codes 38-40 enable, release, trigger fixed-length
// - codes 24, 56 give gear selector bits
// - codes 43, 44 give travel limit switches
// - codes 5, 6 select alternate torque limits
// - terminals one to four share the table
// - status bit 0 terminal one, 9 ten
// - status bit one means terminal active
// - status word unsigned, at most 1023
`timescale 1ns/1ps
`include "difr_defines.svh"
module difr_router
  import difr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // terminal pins
  input wire logic [`DIFR_TERMS-1:0] termPin,
  // axi write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [`DIFR_ADDR_W-1:0] awaddr,
  // axi write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [`DIFR_ADDR_W-1:0] araddr,
  // axi read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // routed functions
  output logic [`DIFR_CODES-1:0] funcActive,
  output logic encoderPosClear,
  output logic [15:0] eventCount,
  output logic [3:0] speedSel,
  output logic [3:0] segmentSel,
  output logic [1:0] modeSel,
  output logic rampUp,
  output logic rampDown,
  output logic rampHold,
  output logic fixLenEnable,
  output logic fixLenRelease,
  output logic fixLenTrigger,
  output logic [1:0] gearSel,
  output logic posLimit,
  output logic revLimit,
  output logic fwdTorqueAlt,
  output logic negTorqueAlt
);

  // ----------------------------------------------------------------
  // terminal synchroniser
  // ----------------------------------------------------------------
  logic [`DIFR_TERMS-1:0] termMeta_reg; // first stage, read by stage two
  logic [`DIFR_TERMS-1:0] termSync_reg; // safe copy of the pins

  // two flops keep metastability out of the decode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      termMeta_reg <= '0;
      termSync_reg <= '0;
    end else begin
      termMeta_reg <= termPin;
      termSync_reg <= termMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // function-select registers
  // ----------------------------------------------------------------
  difr_sel_type selReg [`DIFR_SEL_TERMS]; // code per terminal
  logic [`DIFR_SEL_TERMS-1:0] selWr; // write strobe per terminal

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  logic awHeld_reg; // address taken, waiting for data
  logic wHeld_reg; // data taken, waiting for address
  logic [`DIFR_ADDR_W-1:0] awAddr_reg; // held write address
  logic [31:0] wData_reg; // held write data
  logic [3:0] wStrb_reg; // held byte enables
  logic bValid_reg; // response pending
  logic [1:0] bResp_reg; // response code
  logic doWrite; // both halves present
  logic wrMapped; // address names a select
  logic [`DIFR_ADDR_W-1:0] wrWord; // address with lane bits dropped

  // no new half while a response is waiting: one write at a time
  assign awready = !awHeld_reg && !bValid_reg;
  assign wready = !wHeld_reg && !bValid_reg;
  assign doWrite = awHeld_reg && wHeld_reg;
  assign wrWord = {awAddr_reg[`DIFR_ADDR_W-1:2], 2'b00};
  assign wrMapped = |selWr;
  assign bvalid = bValid_reg;
  assign bresp = bResp_reg;

  // address and data halves taken in either order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_reg <= 1'b0;
      awAddr_reg <= '0;
    end else if (awvalid && awready) begin
      awHeld_reg <= 1'b1;
      awAddr_reg <= awaddr;
    end else if (doWrite) begin
      awHeld_reg <= 1'b0;
    end
  end

  // data half
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wHeld_reg <= 1'b0;
      wData_reg <= '0;
      wStrb_reg <= '0;
    end else if (wvalid && wready) begin
      wHeld_reg <= 1'b1;
      wData_reg <= wdata;
      wStrb_reg <= wstrb;
    end else if (doWrite) begin
      wHeld_reg <= 1'b0;
    end
  end

  // response; writes to read-only words are ignored but answered okay
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bValid_reg <= 1'b0;
      bResp_reg <= `DIFR_RESP_OKAY;
    end else if (doWrite) begin
      bValid_reg <= 1'b1;
      if (wrMapped || wrWord == `DIFR_OFF_STATUS
          || wrWord == `DIFR_OFF_COUNT) begin
        bResp_reg <= `DIFR_RESP_OKAY;
      end else begin
        bResp_reg <= `DIFR_RESP_SLVERR;
      end
    end else if (bready) begin
      bValid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // select storage, one per terminal one to four
  // ----------------------------------------------------------------
  genvar t;
  generate
    for (t = 0; t < `DIFR_SEL_TERMS; t++) begin : g_sel
      difr_sel_type selNext; // merged by byte lane
      // word t sits at byte offset 4*t
      assign selWr[t] = doWrite
        && wrWord == (`DIFR_OFF_SEL1 + `DIFR_ADDR_W'(4 * t));
      assign selNext = {wStrb_reg[1] ? wData_reg[15:8] : selReg[t][15:8],
                        wStrb_reg[0] ? wData_reg[7:0] : selReg[t][7:0]};
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          selReg[t] <= (t == 0) ? `DIFR_RST_SEL1
                     : (t == 1) ? `DIFR_RST_SEL2
                     : (t == 2) ? `DIFR_RST_SEL3 : `DIFR_RST_SEL4;
        end else if (selWr[t]) begin
          selReg[t] <= selNext;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // code decode
  // ----------------------------------------------------------------
  logic [`DIFR_CODES-1:0] funcNext; // decoded functions
  logic [`DIFR_CODES-1:0] funcActive_reg; // registered functions

  genvar c;
  generate
    for (c = 0; c < `DIFR_CODES; c++) begin : g_code
      logic [`DIFR_SEL_TERMS-1:0] hitTerm; // terminals on this code
      for (t = 0; t < `DIFR_SEL_TERMS; t++) begin : g_term
        assign hitTerm[t] = termSync_reg[t]
          && selReg[t] == difr_sel_type'(c);
      end
      // none and reserved codes drive nothing
      if (c == `DIFR_FN_NONE || c == `DIFR_FN_RSV_A
          || c == `DIFR_FN_RSV_B) begin : g_rsv
        assign funcNext[c] = 1'b0;
      end else begin : g_fn
        assign funcNext[c] = |hitTerm;
      end
    end
  endgenerate

  // codes above the table match no generate slot and so do nothing
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      funcActive_reg <= '0;
    end else begin
      funcActive_reg <= funcNext;
    end
  end

  assign funcActive = funcActive_reg;

  // ----------------------------------------------------------------
  // named function outputs
  // ----------------------------------------------------------------
  // encoder position clear
  assign encoderPosClear = funcActive_reg[`DIFR_FN_ENC_CLR];
  assign speedSel = funcActive_reg[`DIFR_FN_SPD3:`DIFR_FN_SPD0];
  assign segmentSel = funcActive_reg[`DIFR_FN_SEG3:`DIFR_FN_SEG0];
  assign modeSel = funcActive_reg[`DIFR_FN_MODE1:`DIFR_FN_MODE0];
  assign rampUp = funcActive_reg[`DIFR_FN_RAMP_UP];
  assign rampDown = funcActive_reg[`DIFR_FN_RAMP_DN];
  assign rampHold = funcActive_reg[`DIFR_FN_RAMP_HOLD];
  assign fixLenEnable = funcActive_reg[`DIFR_FN_FL_EN];
  assign fixLenRelease = funcActive_reg[`DIFR_FN_FL_REL];
  assign fixLenTrigger = funcActive_reg[`DIFR_FN_FL_TRG];
  assign gearSel = {funcActive_reg[`DIFR_FN_GEAR2],
                    funcActive_reg[`DIFR_FN_GEAR1]};
  assign posLimit = funcActive_reg[`DIFR_FN_LIM_POS];
  assign revLimit = funcActive_reg[`DIFR_FN_LIM_REV];
  assign fwdTorqueAlt = funcActive_reg[`DIFR_FN_TQ_FWD];
  assign negTorqueAlt = funcActive_reg[`DIFR_FN_TQ_NEG];

  // ----------------------------------------------------------------
  // internal event counter
  // ----------------------------------------------------------------
  logic cntPrev_reg; // count input one cycle back
  logic cntPulse; // rising edge of the count input
  logic [15:0] eventCount_reg; // wraps at full scale

  assign cntPulse = funcActive_reg[`DIFR_FN_EVT_CNT] && !cntPrev_reg;
  assign eventCount = eventCount_reg;

  // clear wins over a pulse in the same cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cntPrev_reg <= 1'b0;
      eventCount_reg <= '0;
    end else begin
      cntPrev_reg <= funcActive_reg[`DIFR_FN_EVT_CNT];
      if (funcActive_reg[`DIFR_FN_EVT_CLR]) begin
        eventCount_reg <= '0;
      end else if (cntPulse) begin
        eventCount_reg <= eventCount_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // terminal status word
  // ----------------------------------------------------------------
  logic [15:0] statusWord; // bitmap, upper bits zero

  assign statusWord = {6'h00, termSync_reg};

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  logic rValid_reg; // read data pending
  logic [31:0] rData_reg; // read data
  logic [1:0] rResp_reg; // read answer
  logic [`DIFR_ADDR_W-1:0] rdWord; // word address
  logic [15:0] rdMux; // selected value
  logic rdHit; // address is mapped

  assign arready = !rValid_reg;
  assign rvalid = rValid_reg;
  assign rdata = rData_reg;
  assign rresp = rResp_reg;
  assign rdWord = {araddr[`DIFR_ADDR_W-1:2], 2'b00};
  assign rdHit = rdWord <= `DIFR_OFF_COUNT;
  assign rdMux = (rdWord == `DIFR_OFF_SEL1) ? selReg[0]
               : (rdWord == `DIFR_OFF_SEL2) ? selReg[1]
               : (rdWord == `DIFR_OFF_SEL3) ? selReg[2]
               : (rdWord == `DIFR_OFF_SEL4) ? selReg[3]
               : (rdWord == `DIFR_OFF_STATUS) ? statusWord
               : (rdWord == `DIFR_OFF_COUNT) ? eventCount_reg
               : 16'h0000;

  // one read at a time; data stands until rready
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rValid_reg <= 1'b0;
      rData_reg <= '0;
      rResp_reg <= `DIFR_RESP_OKAY;
    end else if (arvalid && arready) begin
      rValid_reg <= 1'b1;
      rData_reg <= {16'h0000, rdMux};
      rResp_reg <= rdHit ? `DIFR_RESP_OKAY : `DIFR_RESP_SLVERR;
    end else if (rready) begin
      rValid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_enc_clear;
    termSync_reg[0] && selReg[0] == 16'h000f |=> encoderPosClear;
  endproperty
  a_enc_clear: assert property (p_enc_clear)
    else $error("encoder clear missed");

  property p_evt_inc;
    cntPulse && !funcActive_reg[`DIFR_FN_EVT_CLR]
      |=> eventCount == $past(eventCount) + 16'h0001;
  endproperty
  a_evt_inc: assert property (p_evt_inc)
    else $error("event count did not step");

  property p_evt_clr;
    termSync_reg[1] && selReg[1] == 16'h003e |=> ##1 eventCount == 16'h0000;
  endproperty
  a_evt_clr: assert property (p_evt_clr)
    else $error("event counter not cleared");

  property p_speed0;
    termSync_reg[0] && selReg[0] == 16'h0011 |=> speedSel[0];
  endproperty
  a_speed0: assert property (p_speed0)
    else $error("speed bit 0 missed");

  property p_seg3;
    termSync_reg[0] && selReg[0] == 16'h001f |=> segmentSel[3];
  endproperty
  a_seg3: assert property (p_seg3)
    else $error("segment bit 3 missed");

  property p_limit;
    termSync_reg[1] && selReg[1] == 16'h002b |=> posLimit && !revLimit
      || selReg[0] == 16'h002c || selReg[2] == 16'h002c
      || selReg[3] == 16'h002c || $past(selReg[0]) == 16'h002c
      || $past(selReg[2]) == 16'h002c || $past(selReg[3]) == 16'h002c;
  endproperty
  a_limit: assert property (p_limit)
    else $error("limit routing wrong");

  property p_status;
    rvalid && rdata[31:10] != 22'h000000 |-> $past(rdWord) != `DIFR_OFF_STATUS;
  endproperty
  a_status: assert property (p_status)
    else $error("status word above ten bits");

  property p_reserved;
    !funcActive_reg[`DIFR_FN_NONE] && !funcActive_reg[`DIFR_FN_RSV_A]
      && !funcActive_reg[`DIFR_FN_RSV_B];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved code drove a function");

  property p_any;
    !termSync_reg[0] && termSync_reg[3] && selReg[3] == 16'h002b
      |=> posLimit;
  endproperty
  a_any: assert property (p_any)
    else $error("shared code not asserted");

endmodule // difr_router

// [dv/difr_term_driver.sv]
// Purpose: switch bank model that drives the ten input terminals
// Assumes: pins are plain levels, high means active
// Notes: pins change only just after a rising edge
`timescale 1ns/1ps
module difr_term_driver (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // pattern asked for by the bench
  input wire logic [9:0] want,
  // terminal pins
  output logic [9:0] termPin
);
  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  // all terminals inactive during reset, so nothing fires on release;
  // a registered follow keeps pin edges away from the sampling edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      termPin <= 10'h000;
    end else begin
      termPin <= want;
    end
  end
endmodule // difr_term_driver

// [dv/tb_top.sv]
// Purpose: self-checking bench for the input function router
// Assumes: pins come from the switch bank model, bus is AXI4-Lite
// Notes: bus waits end only by the global cycle ceiling
`timescale 1ns/1ps
`include "difr_defines.svh"
module tb_top
  import difr_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  // clock, reset and counters
  logic clk = 1'b0;
  logic nrst = 1'b0;
  int cycles = 0;
  int mismatches = 0;
  int comparisons = 0;
  // bus master side, all driven after a rising edge
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [`DIFR_ADDR_W-1:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid;
  difr_resp_type bresp, rresp;
  logic [31:0] rdata;
  // routed functions
  logic [`DIFR_CODES-1:0] funcActive;
  logic [15:0] eventCount;
  logic [3:0] speedSel, segmentSel;
  logic [1:0] modeSel, gearSel;
  logic rampUp, rampDown, rampHold, fixLenEnable, fixLenRelease;
  logic fixLenTrigger, posLimit, revLimit, fwdTorqueAlt, negTorqueAlt;
  logic encoderPosClear;
  // pins asked of the switch model, and the pins themselves
  logic [9:0] want = 10'h000;
  logic [9:0] termPin;
  // named outputs gathered in one vector
  wire [22:0] named = {encoderPosClear, speedSel, segmentSel, modeSel,
    rampUp, rampDown, rampHold, fixLenEnable, fixLenRelease,
    fixLenTrigger, gearSel, posLimit, revLimit, fwdTorqueAlt, negTorqueAlt};
  // one table row: code written, function index expected (-1 none)
  typedef struct {int code; int idx;} difr_row_type;
  difr_row_type rows[30] = '{'{5, 5}, '{6, 6}, '{15, 15}, '{17, 17},
    '{18, 18}, '{19, 19}, '{20, 20}, '{24, 24}, '{28, 28}, '{29, 29},
    '{30, 30}, '{31, 31}, '{36, 36}, '{37, 37}, '{38, 38}, '{39, 39},
    '{40, 40}, '{43, 43}, '{44, 44}, '{56, 56}, '{61, 61}, '{62, 62},
    '{63, 63}, '{64, 64}, '{65, 65}, '{0, -1}, '{33, -1}, '{71, -1},
    '{76, -1}, '{99, -1}};
  // select reset values
  logic [31:0] rstVal[4] = '{32'h0000_0001, 32'h0000_002a, 32'h0, 32'h0};
  // ----------------------------------------------------------------
  // design and switch model
  // ----------------------------------------------------------------
  difr_router i_difr_router (.clk(clk), .nrst(nrst), .termPin(termPin),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .funcActive(funcActive), .encoderPosClear(encoderPosClear),
    .eventCount(eventCount), .speedSel(speedSel),
    .segmentSel(segmentSel), .modeSel(modeSel), .rampUp(rampUp),
    .rampDown(rampDown), .rampHold(rampHold),
    .fixLenEnable(fixLenEnable), .fixLenRelease(fixLenRelease),
    .fixLenTrigger(fixLenTrigger), .gearSel(gearSel),
    .posLimit(posLimit), .revLimit(revLimit),
    .fwdTorqueAlt(fwdTorqueAlt), .negTorqueAlt(negTorqueAlt));
  difr_term_driver i_difr_term_driver (.clk(clk), .nrst(nrst),
    .want(want), .termPin(termPin));
  // ----------------------------------------------------------------
  // clock, ceiling and verdict
  // ----------------------------------------------------------------
  // 8 ns period
  always #4 clk = ~clk;
  // a hang counts as a mismatch; the run needs well under this
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // expectations and comparisons
  // ----------------------------------------------------------------
  function automatic logic [75:0] oneHot(input int idx);
    oneHot = '0;
    if (idx >= 0) oneHot[idx] = 1'b1;
  endfunction
  // gathers the named outputs from a one-bit-per-code vector
  function automatic logic [22:0] namedOf(input logic [75:0] e);
    namedOf = {e[15], e[20:17], e[31:28], e[37:36], e[63], e[64], e[65],
      e[38], e[39], e[40], e[56], e[24], e[43], e[44], e[5], e[6]};
  endfunction
  task automatic checkFn(input logic [75:0] got, input logic [75:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t functions got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic checkReg(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic checkResp(input difr_resp_type got,
                           input difr_resp_type exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t response got %b exp %b", $time, got, exp);
    end
  endtask
  // ----------------------------------------------------------------
  // bus and pin tasks
  // ----------------------------------------------------------------
  // address and data offered together, each released when taken
  task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
                          input logic [3:0] s, output difr_resp_type r);
    bit awDone, wDone, bDone;
    awDone = 0;
    wDone = 0;
    bDone = 0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    bready <= 1'b1;
    while (!bDone) begin
      @(posedge clk);
      if (!awDone && awready === 1'b1) begin
        awvalid <= 1'b0;
        awDone = 1;
      end
      if (!wDone && wready === 1'b1) begin
        wvalid <= 1'b0;
        wDone = 1;
      end
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        bDone = 1;
      end
    end
  endtask
  task automatic axiRead(input logic [11:0] a, output logic [31:0] d,
                         output difr_resp_type r);
    bit rDone;
    rDone = 0;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!rDone) begin
      @(posedge clk);
      if (arvalid === 1'b1 && arready === 1'b1) begin
        arvalid <= 1'b0;
      end
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        rDone = 1;
      end
    end
  endtask
  // pin change plus model, sync and decode delay, with margin
  task automatic pins(input logic [9:0] p);
    want <= p;
    repeat (6) @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    difr_resp_type r;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    // select reset values, then the empty status word
    for (int i = 0; i < 4; i++) begin
      axiRead(12'(4 * i), d, r);
      checkReg(d, rstVal[i]);
      checkResp(r, `DIFR_RESP_OKAY);
    end
    axiRead(`DIFR_OFF_STATUS, d, r);
    checkReg(d, 32'h0);
    foreach (rows[i]) begin
      axiWrite(`DIFR_OFF_SEL1, 32'(rows[i].code), 4'h3, r);
      pins(10'h001);
      checkFn(funcActive, oneHot(rows[i].idx));
      checkFn({53'h0, named}, {53'h0, namedOf(oneHot(rows[i].idx))});
      pins(10'h000);
    end
    // terminals two to four share one code
    for (int i = 1; i < 4; i++) begin
      axiWrite(12'(4 * i), 32'd43, 4'h3, r);
    end
    pins(10'h00a);
    checkFn(funcActive, oneHot(43));
    pins(10'h008);
    checkFn(funcActive, oneHot(43));
    pins(10'h000);
    checkFn(funcActive, 76'h0);
    // new code seen one edge after the write lands
    pins(10'h001);
    axiWrite(`DIFR_OFF_SEL1, 32'd44, 4'h3, r);
    #1;
    checkFn(funcActive, oneHot(44));
    // event counter: clear first, three pulses, then clear again
    axiWrite(`DIFR_OFF_SEL1, 32'd61, 4'h3, r);
    axiWrite(`DIFR_OFF_SEL2, 32'd62, 4'h3, r);
    pins(10'h002);
    pins(10'h000);
    checkReg({16'h0, eventCount}, 32'h0);
    repeat (3) begin
      pins(10'h001);
      pins(10'h000);
    end
    checkReg({16'h0, eventCount}, 32'h3);
    axiRead(`DIFR_OFF_COUNT, d, r);
    checkReg(d, 32'h3);
    pins(10'h002);
    checkReg({16'h0, eventCount}, 32'h0);
    pins(10'h000);
    // status bitmap, low terminal at bit 0
    pins(10'h2a5);
    axiRead(`DIFR_OFF_STATUS, d, r);
    checkReg(d, 32'h0000_02a5);
    pins(10'h3ff);
    axiRead(`DIFR_OFF_STATUS, d, r);
    checkReg(d, 32'h0000_03ff);
    pins(10'h000);
    axiRead(`DIFR_OFF_STATUS, d, r);
    checkReg(d, 32'h0);
    // unmapped place, read-only status and a single byte lane
    axiRead(12'h100, d, r);
    checkResp(r, `DIFR_RESP_SLVERR);
    checkReg(d, 32'h0);
    axiWrite(12'h100, 32'h0000_0011, 4'hf, r);
    checkResp(r, `DIFR_RESP_SLVERR);
    axiWrite(`DIFR_OFF_STATUS, 32'h0000_0011, 4'hf, r);
    checkResp(r, `DIFR_RESP_OKAY);
    axiWrite(`DIFR_OFF_SEL3, 32'h1234_5678, 4'h1, r);
    checkResp(r, `DIFR_RESP_OKAY);
    axiRead(`DIFR_OFF_SEL3, d, r);
    checkReg(d, 32'h0000_0078);
    // mid-run reset: count, functions and selects back to reset values
    pins(10'h001);
    checkReg({16'h0, eventCount}, 32'h1);
    nrst <= 1'b0;
    pins(10'h000);
    checkFn(funcActive, 76'h0);
    checkReg({16'h0, eventCount}, 32'h0);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      axiRead(12'(4 * i), d, r);
      checkReg(d, rstVal[i]);
    end
    conclude();
  end
endmodule // tb_top
